/* File: design/cell_consts.svh */
// register offsets, field positions, codes and reset values of the logic cell
`ifndef CELL_CONSTS_SVH
`define CELL_CONSTS_SVH

// =====================================================================
// register byte offsets
`define OFF_CFG        8'h00
`define OFF_AUX        8'h04
`define OFF_TABLE      8'h08
`define OFF_STATUS     8'h0c

// =====================================================================
// configuration register fields (per-element fields: base + element, two-bit ones base + 2*element)
`define CFG_EDGE_NEG   0
`define CFG_CE_TIED    2
`define CFG_SR_SET     4
`define CFG_SR_DIS     6
`define CFG_DSEL       8
`define CFG_BYP        12
`define CFG_BSEL       14
`define CFG_MAP_CE     18
`define CFG_MAP_SR     20
`define CFG_MAP_DIN    22
`define CFG_MAP_H1     24
`define CFG_MODE       26
`define CFG_F_RAM      28
`define CFG_G_RAM      29
`define CFG_LEVEL      30
`define CFG_WCLK_NEG   31

// =====================================================================
// auxiliary register fields
`define AUX_HTAB       0
`define AUX_H0_F       8
`define AUX_H2_G       9
`define AUX_GI_INV     10
`define AUX_GI_NODE    11
`define AUX_MASK       32'h0000_0fff

// =====================================================================
// table register fields
`define TAB_F          0
`define TAB_G          16

// =====================================================================
// status register fields
`define ST_Q           0
`define ST_OUT         2
`define ST_SPO         4
`define ST_DPO         5
`define ST_H           6

// =====================================================================
// codes
`define MODE_LOGIC     2'h0
`define MODE_TWO16     2'h1
`define MODE_ONE32     2'h2
`define MODE_DUAL      2'h3
`define DSEL_F         2'h0
`define DSEL_G         2'h1
`define DSEL_H         2'h2
`define DSEL_DIRECT    2'h3

// =====================================================================
// reset values and the value read from unmapped offsets
`define CFG_RST        32'h0000_0000
`define AUX_RST        32'h0000_0000
`define TAB_RST        16'h0000
`define RD_UNMAPPED    32'h0000_0000

`endif

/* File: design/cell_pkg.sv */
// types shared by the logic cell design
package cell_pkg;
`include "cell_consts.svh"

  typedef enum logic [1:0] {
    LOGIC_ONLY = `MODE_LOGIC,
    TWO_BY_16  = `MODE_TWO16,
    ONE_BY_32  = `MODE_ONE32,
    DUAL_PORT  = `MODE_DUAL
  } ram_mode_e;

  typedef struct packed {
    logic        wait_req;
    logic [31:0] rdata;
    logic [31:0] cfg;
    logic [31:0] aux;
    logic [15:0] ftab;
    logic [15:0] gtab;
    logic        k_prev;
    logic [1:0]  q;
    logic [1:0]  out;
    logic        primary_port_out;
    logic        secondary_port_out;
    logic        init_pend;
    logic        pend;
    logic        pend_we;
    logic [3:0]  pend_fa;
    logic [3:0]  pend_ga;
    logic        pend_d0;
    logic        pend_d1;
  } state_s;

endpackage

/* File: design/logic_cell.sv */
// logic cell: two storage elements, control mapping and table ram
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`include "cell_consts.svh"

module logic_cell
  import cell_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              cell_clk_i,
  input  wire logic [3:0]        cell_control_i,
  input  wire logic [3:0]        first_table_inputs_i,
  input  wire logic [3:0]        second_table_inputs_i,
  input  wire logic              global_init_pin_i,
  input  wire logic              global_init_node_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic                   registered_out_first_o,
  output logic                   registered_out_second_o,
  output logic                   primary_port_out_o,
  output logic                   secondary_port_out_o
);

  // =====================================================================
  // elaboration checks
  if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr_w
    $error("ADDR_W must lie between 4 and 8");
  end

  // =====================================================================
  // functions
  function automatic logic lut16(input logic [15:0] tab, input logic [3:0] a);
    return tab[a];
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // =====================================================================
  // decode of configuration and pins
  state_s      state_q;
  state_s      state_d;
  logic [31:0] cfg;
  logic [31:0] aux;
  ram_mode_e   mode;
  logic        is_ram;
  logic        level_mode;
  logic        ce_line;
  logic        sr_h0;
  logic        din_h2;
  logic        h1_line;
  logic [3:0]  g_addr;
  logic        f_rd;
  logic        g_rd;
  logic        spo_v;
  logic        h0_in;
  logic        h2_in;
  logic        h_v;
  logic        k_rise;
  logic        k_fall;
  logic        wclk_edge;
  logic        gi;
  logic        req;
  logic        acc_wr;
  logic        hit_cfg;
  logic        hit_aux;
  logic        hit_tab;
  logic        hit_st;

  assign cfg     = state_q.cfg;
  assign aux     = state_q.aux;
  assign mode    = ram_mode_e'(cfg[`CFG_MODE +: 2]);
  assign is_ram  = (mode != LOGIC_ONLY);
  // dual port only exists with edge-triggered writes
  assign level_mode = cfg[`CFG_LEVEL] & (mode != DUAL_PORT);

  // ram mode: sr/h0 line is write enable, din/h2 is d0, h1 is d1
  assign ce_line = cell_control_i[cfg[`CFG_MAP_CE  +: 2]];
  assign sr_h0   = cell_control_i[cfg[`CFG_MAP_SR  +: 2]];
  assign din_h2  = cell_control_i[cfg[`CFG_MAP_DIN +: 2]];
  assign h1_line = cell_control_i[cfg[`CFG_MAP_H1  +: 2]];

  // reads are the same in every mode except 32x1, where g shares the first address and h1 picks the table
  assign g_addr = (mode == ONE_BY_32) ? first_table_inputs_i : second_table_inputs_i;
  assign f_rd   = lut16(state_q.ftab, first_table_inputs_i);
  assign g_rd   = lut16(state_q.gtab, g_addr);
  assign spo_v  = (mode == ONE_BY_32 && h1_line) ? g_rd : f_rd;

  assign h0_in = aux[`AUX_H0_F] ? f_rd : sr_h0;
  assign h2_in = aux[`AUX_H2_G] ? g_rd : din_h2;
  assign h_v   = aux[`AUX_HTAB + {h2_in, h1_line, h0_in}];

  // cell clock is sampled; edges seen one reference cycle late
  assign k_rise    = cell_clk_i & ~state_q.k_prev;
  assign k_fall    = ~cell_clk_i & state_q.k_prev;
  assign wclk_edge = cfg[`CFG_WCLK_NEG] ? k_fall : k_rise;

  assign gi = aux[`AUX_GI_NODE] ? global_init_node_i
                                : (global_init_pin_i ^ aux[`AUX_GI_INV]);

  assign req     = avs_read_i | avs_write_i;
  assign acc_wr  = avs_write_i & ~state_q.wait_req;
  assign hit_cfg = (avs_address_i == ADDR_W'(`OFF_CFG));
  assign hit_aux = (avs_address_i == ADDR_W'(`OFF_AUX));
  assign hit_tab = (avs_address_i == ADDR_W'(`OFF_TABLE));
  assign hit_st  = (avs_address_i == ADDR_W'(`OFF_STATUS));

  // =====================================================================
  // next state
  always_comb begin
    logic        do_wr;
    logic [3:0]  w_fa;
    logic [3:0]  w_ga;
    logic        w_d0;
    logic        w_d1;
    logic [31:0] tab_w;
    logic        dv;
    logic        edge_i;
    logic        en_i;
    logic        sr_i;
    do_wr  = 1'b0;
    w_fa   = 4'h0;
    w_ga   = 4'h0;
    w_d0   = 1'b0;
    w_d1   = 1'b0;
    tab_w  = 32'h0000_0000;
    dv     = 1'b0;
    edge_i = 1'b0;
    en_i   = 1'b0;
    sr_i   = 1'b0;
    state_d = state_q;
    state_d.k_prev    = cell_clk_i;
    state_d.init_pend = 1'b0;

    // bus: one wait cycle, then the access completes
    state_d.wait_req = ~(req & state_q.wait_req);
    if (avs_read_i && state_q.wait_req) begin
      if (hit_cfg) begin
        state_d.rdata = cfg;
      end else if (hit_aux) begin
        state_d.rdata = aux;
      end else if (hit_tab) begin
        state_d.rdata = {state_q.gtab, state_q.ftab};
      end else if (hit_st) begin
        state_d.rdata = `RD_UNMAPPED;
        state_d.rdata[`ST_Q +: 2]   = state_q.q;
        state_d.rdata[`ST_OUT +: 2] = state_q.out;
        state_d.rdata[`ST_SPO]      = state_q.primary_port_out;
        state_d.rdata[`ST_DPO]      = state_q.secondary_port_out;
        state_d.rdata[`ST_H]        = h_v;
      end else begin
        state_d.rdata = `RD_UNMAPPED;
      end
    end

    // ram write: level mode writes while enable high, edge mode one
    // cycle after the sampled edge (the internal write pulse)
    if (level_mode) begin
      do_wr = is_ram & sr_h0;
      w_fa  = first_table_inputs_i;
      w_ga  = second_table_inputs_i;
      w_d0  = din_h2;
      w_d1  = h1_line;
    end else begin
      do_wr = state_q.pend & state_q.pend_we;
      w_fa  = state_q.pend_fa;
      w_ga  = state_q.pend_ga;
      w_d0  = state_q.pend_d0;
      w_d1  = state_q.pend_d1;
    end
    state_d.pend    = is_ram & ~level_mode & wclk_edge;
    state_d.pend_we = sr_h0;
    state_d.pend_fa = first_table_inputs_i;
    state_d.pend_ga = second_table_inputs_i;
    state_d.pend_d0 = din_h2;
    state_d.pend_d1 = h1_line;

    if (do_wr) begin
      case (mode)
        TWO_BY_16: begin
          // either table alone may be ram, the other stays logic
          if (cfg[`CFG_F_RAM]) begin
            state_d.ftab[w_fa] = w_d0;
          end
          if (cfg[`CFG_G_RAM]) begin
            state_d.gtab[w_ga] = w_d1;
          end
        end
        ONE_BY_32: begin
          if (w_d1) begin
            state_d.gtab[w_fa] = w_d0;
          end else begin
            state_d.ftab[w_fa] = w_d0;
          end
        end
        DUAL_PORT: begin
          state_d.ftab[w_fa] = w_d0;
          state_d.gtab[w_fa] = w_d0;
        end
        default: begin
        end
      endcase
    end

    // configuration writes; each counts as a reconfiguration
    if (acc_wr) begin
      if (hit_cfg) begin
        state_d.cfg       = wmask(cfg, avs_writedata_i, avs_byteenable_i);
        state_d.init_pend = 1'b1;
      end else if (hit_aux) begin
        state_d.aux       = wmask(aux, avs_writedata_i, avs_byteenable_i) & `AUX_MASK;
        state_d.init_pend = 1'b1;
      end else if (hit_tab) begin
        tab_w = wmask({state_q.gtab, state_q.ftab}, avs_writedata_i, avs_byteenable_i);
        state_d.ftab      = tab_w[`TAB_F +: 16];
        state_d.gtab      = tab_w[`TAB_G +: 16];
        state_d.init_pend = 1'b1;
      end
    end

    // storage elements; global init never touches the tables
    for (int i = 0; i < 2; i++) begin
      case (cfg[`CFG_DSEL + 2*i +: 2])
        `DSEL_F: dv = f_rd;
        `DSEL_G: dv = g_rd;
        `DSEL_H: dv = h_v;
        default: dv = din_h2;
      endcase
      edge_i = cfg[`CFG_EDGE_NEG + i] ? k_fall : k_rise;
      en_i   = cfg[`CFG_CE_TIED + i] | ce_line;
      // in ram mode this line carries write enable, not set/reset
      sr_i   = sr_h0 & ~cfg[`CFG_SR_DIS + i] & ~is_ram;
      if (gi || state_q.init_pend || sr_i) begin
        state_d.q[i] = cfg[`CFG_SR_SET + i];
      end else if (edge_i && en_i) begin
        state_d.q[i] = dv;
      end
      state_d.out[i] = cfg[`CFG_BYP + i] ? cell_control_i[cfg[`CFG_BSEL + 2*i +: 2]]
                                         : state_d.q[i];
    end

    state_d.primary_port_out = spo_v;
    state_d.secondary_port_out = g_rd;
  end

  // =====================================================================
  // state register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q           <= '0;
      state_q.wait_req  <= 1'b1;
      state_q.cfg       <= `CFG_RST;
      state_q.aux       <= `AUX_RST;
      state_q.ftab      <= `TAB_RST;
      state_q.gtab      <= `TAB_RST;
      state_q.init_pend <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign avs_readdata_o          = state_q.rdata;
  assign avs_waitrequest_o       = state_q.wait_req;
  assign registered_out_first_o  = state_q.out[0];
  assign registered_out_second_o = state_q.out[1];
  assign primary_port_out_o      = state_q.primary_port_out;
  assign secondary_port_out_o    = state_q.secondary_port_out;

endmodule

/* File: sim/logic_cell_sva.sv */
// concurrent checks on the logic cell ports
`timescale 1ns/10ps
`include "cell_consts.svh"
// =====================================================================
// checker
module logic_cell_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic              ref_clk_i,
  input wire logic              rstn_i,
  input wire logic              cell_clk_i,
  input wire logic [3:0]        cell_control_i,
  input wire logic [3:0]        first_table_inputs_i,
  input wire logic [3:0]        second_table_inputs_i,
  input wire logic              global_init_pin_i,
  input wire logic              global_init_node_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic [31:0]       avs_writedata_i,
  input wire logic [3:0]        avs_byteenable_i,
  input wire logic [31:0]       avs_readdata_o,
  input wire logic              avs_waitrequest_o,
  input wire logic              registered_out_first_o,
  input wire logic              registered_out_second_o,
  input wire logic              primary_port_out_o,
  input wire logic              secondary_port_out_o
);
  logic [31:0] cfg_q;
  logic [31:0] aux_q;
  logic        wr_ok;
  logic        cfg_wr;
  logic        sr0;
  logic        sr1;
  logic        gi;
  logic [1:0]  outs;

  // shadow copies, so the checks know the configured set values
  assign wr_ok  = avs_write_i && !avs_waitrequest_o;
  assign cfg_wr = wr_ok && avs_address_i == ADDR_W'(`OFF_CFG);
  assign outs   = {registered_out_second_o, registered_out_first_o};
  assign sr0    = cfg_q[29:26] == 4'h0 && !cfg_q[6] && !cfg_q[12] && cell_control_i[cfg_q[21:20]];
  assign sr1    = cfg_q[29:26] == 4'h0 && !cfg_q[7] && !cfg_q[13] && cell_control_i[cfg_q[21:20]];
  assign gi     = (aux_q[11] ? global_init_node_i : global_init_pin_i ^ aux_q[10])
                  && cfg_q[13:12] == 2'h0;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q <= 32'h0;
      aux_q <= 32'h0;
    end else begin
      if (cfg_wr) cfg_q <= avs_writedata_i;
      if (wr_ok && avs_address_i == ADDR_W'(`OFF_AUX)) aux_q <= avs_writedata_i & `AUX_MASK;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  req_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered after one cycle");
  wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  idle_wait_a: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("waitrequest low without a request");
  rst_out_a: assert property ($rose(rstn_i) |-> outs == 2'h0)
    else $error("outputs not cleared after reset");
  reconf_set_a: assert property (cfg_wr && avs_writedata_i[13:12] == 2'h0
    |-> ##[1:3] outs == cfg_q[5:4]) else $error("reconfiguration did not force elements");
  sr_first_a: assert property (sr0 [*3] |-> registered_out_first_o == cfg_q[4])
    else $error("first element ignores local set/reset");
  sr_second_a: assert property (sr1 [*3] |-> registered_out_second_o == cfg_q[5])
    else $error("second element ignores local set/reset");
  ginit_force_a: assert property (gi [*3] |-> outs == cfg_q[5:4])
    else $error("global init did not force elements");
endmodule

bind logic_cell logic_cell_sva #(.ADDR_W(ADDR_W)) checker_inst (.*);

/* File: sim/cell_user_logic.sv */
// far-side user logic: makes cell clock pulses on request
`timescale 1ns/10ps
// =====================================================================
// partner
module cell_user_logic (
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       go_i,
  input  wire logic [2:0] hi_i,
  output logic            cell_clk_o
);
  logic [2:0] cnt_q;

  // clock stands still between pulses; high phase is hi_i cycles, at least one; with hi_i zero it lasts while go_i is held
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cell_clk_o <= 1'b0;
      cnt_q      <= 3'h0;
    end else if (go_i && cnt_q == 3'h0) begin
      cell_clk_o <= 1'b1;
      cnt_q      <= hi_i;
    end else if (cnt_q > 3'h1) begin
      cnt_q <= cnt_q - 3'h1;
    end else begin
      cell_clk_o <= 1'b0;
      cnt_q      <= 3'h0;
    end
  end
endmodule

/* File: sim/tb_logic_cell_storage_lut_ram.sv */
// testbench for the logic cell: elements, control mapping, table ram
`timescale 1ns/10ps
`include "cell_consts.svh"
// =====================================================================
// bench
module tb_logic_cell_storage_lut_ram;
  logic        ref_clk, rstn, go, pin, node, cell_clk, rd, wr, wreq, qa, qb, po, so, neg, lvl, we;
  logic [2:0]  hi;
  logic [3:0]  ctl, fin, gin, cr, cf;
  logic [7:0]  addr;
  logic [31:0] wdat, rdat, r;
  logic [15:0] ft, gt;
  int          n_fail, n_compared, seed, i, m;

  logic_cell #(.ADDR_W(8)) DUT (.ref_clk_i(ref_clk), .rstn_i(rstn), .cell_clk_i(cell_clk),
    .cell_control_i(ctl), .first_table_inputs_i(fin), .second_table_inputs_i(gin),
    .global_init_pin_i(pin), .global_init_node_i(node), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .registered_out_first_o(qa),
    .registered_out_second_o(qb), .primary_port_out_o(po), .secondary_port_out_o(so));
  cell_user_logic far_side (.ref_clk_i(ref_clk), .rstn_i(rstn), .go_i(go), .hi_i(hi),
    .cell_clk_o(cell_clk));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] ram_cfg(input int md, input logic l, input logic n);
    return 32'h3390_0000 | (32'(md) << 26) | {n, l, 30'h0};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // avalon access; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge ref_clk);
    addr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (wreq !== 1'b0 && t < 40);
    r = rdat;
    if (wreq !== 1'b0) n_fail++;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // cell clock pulse: controls c at the rising edge, mid at the falling edge
  task automatic pulse(input logic [2:0] h, input logic [3:0] c, input logic [3:0] mid);
    @(posedge ref_clk);
    ctl <= c;
    go <= 1'b1;
    hi <= h;
    cyc(1);
    go <= 1'b0;
    cyc(2);
    ctl <= mid;
    cyc(h + 5);
    @(negedge ref_clk);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    seed = 32'hf29e;
    n_fail = 0;
    n_compared = 0;
    {rstn, go, pin, node, rd, wr, hi, ctl, fin, gin, addr, wdat, ft, gt} = '0;
    cyc(5);
    rstn <= 1'b1;
    bus(1'b1, 8'h10, 32'hffff_ffff);
    for (i = 0; i < 5; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      cmp(r, 32'h0);
    end
    // direct input, element 1 on falling edge, enable tied
    bus(1'b1, `OFF_CFG, 32'h0390_0fce);
    for (i = 0; i < 6; i++) begin
      cr = 4'($random(seed));
      cf = 4'($random(seed));
      pulse(3'h4, cr, cf);
      cmp({qb, qa}, {cf[2], cr[2]});
    end
    bus(1'b1, `OFF_CFG, 32'h0390_0fc2);
    pulse(3'h4, 4'h4, 4'h4);
    cmp({qb, qa}, 32'h0);
    pulse(3'h4, 4'h5, 4'h5);
    cmp({qb, qa}, 32'h3);
    for (i = 0; i < 2; i++) begin
      bus(1'b1, `OFF_CFG, i ? 32'h0390_0f7e : 32'h0390_0fbe);
      pulse(3'h4, 4'h0, 4'h0);
      cmp({qb, qa}, 32'h0);
      pulse(3'h4, 4'h2, 4'h2);
      cmp({qb, qa}, i ? 32'h2 : 32'h1);
      ctl <= 4'h0;
    end
    @(posedge ref_clk);
    pin <= 1'b1;
    cyc(4);
    @(negedge ref_clk);
    cmp({qb, qa}, 32'h3);
    bus(1'b1, `OFF_AUX, 32'h0000_0400);
    pulse(3'h4, 4'h0, 4'h0);
    cmp({qb, qa}, 32'h0);
    @(posedge ref_clk);
    pin <= 1'b0;
    cyc(4);
    @(negedge ref_clk);
    cmp({qb, qa}, 32'h3);
    // init taken from an internal node instead of the pin
    bus(1'b1, `OFF_AUX, 32'h0000_0800);
    pulse(3'h4, 4'h0, 4'h0);
    cmp({qb, qa}, 32'h0);
    @(posedge ref_clk);
    node <= 1'b1;
    cyc(4);
    @(negedge ref_clk);
    cmp({qb, qa}, 32'h3);
    @(posedge ref_clk);
    node <= 1'b0;
    bus(1'b1, `OFF_CFG, 32'h0390_9f7e);
    for (i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      ctl <= 4'($random(seed));
      cyc(2);
      @(negedge ref_clk);
      cmp(qa, ctl[2]);
    end
    bus(1'b1, `OFF_AUX, 32'h0);
    // ram: 16x2, 32x1, dual port; both write edges; level strobe
    for (i = 0; i < 24; i++) begin
      @(posedge ref_clk);
      ctl <= 4'h0;
      m = i % 3 + 1;
      neg = i[2];
      lvl = (m == 1) && i[3];
      bus(1'b1, `OFF_CFG, ram_cfg(m, lvl, neg));
      cr = 4'($random(seed));
      cf = {cr[3:2], 1'($random(seed)), cr[0]};
      fin <= 4'($random(seed));
      gin <= 4'($random(seed));
      if (lvl) begin
        @(posedge ref_clk);
        ctl <= cr;
        cyc(2);
        ctl <= cf;
        cyc(4);
        @(negedge ref_clk);
      end else begin
        pulse(3'h2, cr, cf);
      end
      we = lvl ? (cr[1] | cf[1]) : (neg ? cf[1] : cr[1]);
      if (we) begin
        if (m == 2 && cr[3]) gt[fin] = cr[2];
        else ft[fin] = cr[2];
        if (m == 1) gt[gin] = cr[3];
        if (m == 3) gt[fin] = cr[2];
      end
      cmp(po, (m == 2 && cr[3]) ? gt[fin] : ft[fin]);
      if (m != 2) cmp(so, gt[gin]);
    end
    bus(1'b0, `OFF_TABLE, 32'h0);
    cmp(r, {gt, ft});
    @(posedge ref_clk);
    pin <= 1'b1;
    cyc(4);
    pin <= 1'b0;
    bus(1'b0, `OFF_TABLE, 32'h0);
    cmp(r, {gt, ft});
    tally_and_finish();
  end
endmodule
